// ===== src/rx_path_ctl.sv
`default_nettype none

module rx_path_ctl import rx_ctl_pkg::*; #(
    parameter int unsigned PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ,
    parameter int unsigned FIFO_AW        = 6
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        demod_bit_i,
    input  wire logic        demod_bit_vld_i,
    input  wire logic        rssi_cmp_i,
    input  wire logic        phase_jump_detector_i,
    input  wire logic        preamble_det_i,
    input  wire logic        sync_det_i,
    input  wire logic        node_det_i,
    output logic      [2:0]  gpio_o,
    output logic      [2:0]  gpio_oe_o,
    output logic             rx_active_o,
    output logic      [1:0]  limiter_level_trim_o,
    output logic      [1:0]  mixer_current_set_o,
    output logic      [1:0]  frontend_amp_config_o,
    output logic      [1:0]  frontend_amp_current_o
);
    localparam logic [15:0] SHORT_SETTLE = 16'(RFS_TO_RX_CYC - 1);
    localparam logic [15:0] LONG_SETTLE  = 16'(PLL_SETTLE_CYC + RFS_TO_RX_CYC - 1);
    localparam logic [6:0]  TICK_LAST    = 7'(TICK_CYC - 1);

    fifo_if #(.AW(FIFO_AW)) fq ();

    logic [13:0]  ctrl_r;
    logic [15:0]  t1_r;
    logic [15:0]  t2_r;
    logic [15:0]  sleep_per_r;
    logic [1:0]   lay_r;
    logic [7:0]   flen_r;
    logic [5:0]   flags_r;
    radio_state_e state_r;
    win_state_e   win_r;
    win_state_e   win_nxt;
    logic [15:0]  settle_r;
    logic [6:0]   tick_cnt_r;
    logic [15:0]  win_cnt_r;
    logic [15:0]  sleep_cnt_r;
    logic         rd_wait_r;
    logic         ph_on_r;
    logic [2:0]   bit_cnt_r;
    logic [6:0]   sh_r;
    logic [8:0]   byte_idx_r;
    logic [8:0]   total_r;
    logic [8:0]   tot_nxt;
    logic         win_exit;
    logic         hit1;

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    wire         acc      = psel_i && penable_i;
    wire  [7:0]  addr     = paddr_i & 8'hFC;
    wire         fifo_rd  = acc && !pwrite_i && addr == ADDR_FIFO;
    wire         bus_wr   = acc && pwrite_i;
    wire         cmd_wr   = bus_wr && addr == ADDR_CMD;
    wire  [3:0]  cmd      = pwdata_i[3:0];
    wire         pkt_mode = ctrl_r[CTRL_PKT];
    wire  [1:0]  dout_sel = ctrl_r[CTRL_DOUT +: 2];
    wire         tmr_en   = ctrl_r[CTRL_TEN];
    wire  [3:0]  ext      = ctrl_r[CTRL_EXT +: 4];
    wire  [2:0]  duty     = ctrl_r[CTRL_DUTY +: 3];
    wire  [1:0]  pwr      = ctrl_r[CTRL_PWR +: 2];
    wire         in_rx    = state_r == ST_RX;

    // FIFO reads wait one cycle for the registered memory output
    assign pready_o = !(fifo_rd && !rd_wait_r);
    assign fq.rd_en = fifo_rd && !rd_wait_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_wait_r <= 1'b0;
        end else begin
            rd_wait_r <= fifo_rd && !rd_wait_r;
        end
    end

    // Unmapped addresses answer with an error
    always_comb begin
        pslverr_o = 1'b0;
        case (addr)
            ADDR_CTRL:   prdata_o = {18'h0, ctrl_r};
            ADDR_WIN:    prdata_o = {t2_r, t1_r};
            ADDR_SLEEP:  prdata_o = {16'h0, sleep_per_r};
            ADDR_CMD:    prdata_o = 32'h0;
            ADDR_STATUS: prdata_o = {{(25 - FIFO_AW){1'b0}}, fq.level, win_r, state_r};
            ADDR_FLAGS:  prdata_o = {26'h0, flags_r};
            ADDR_FIFO:   prdata_o = {24'h0, fq.rd_data};
            ADDR_PKT:    prdata_o = {22'h0, flen_r, lay_r};
            default: begin
                prdata_o  = 32'h0;
                pslverr_o = acc;
            end
        endcase
    end

    // Configuration writes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ctrl_r      <= CTRL_RST;
            t1_r        <= T1_RST;
            t2_r        <= T2_RST;
            sleep_per_r <= SLEEP_RST;
            lay_r       <= LAY_LEN_FIRST;
            flen_r      <= FLEN_RST;
        end else if (bus_wr) begin
            case (addr)
                ADDR_CTRL:  ctrl_r <= pwdata_i[13:0];
                ADDR_WIN: begin
                    t1_r <= pwdata_i[15:0];
                    t2_r <= pwdata_i[31:16];
                end
                ADDR_SLEEP: sleep_per_r <= pwdata_i[15:0];
                ADDR_PKT: begin
                    lay_r  <= pwdata_i[1:0];
                    flen_r <= pwdata_i[9:2];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebase and radio state

    wire tick = tick_cnt_r == TICK_LAST;
    wire wake = state_r == ST_SLEEP && duty != DUTY_MANUAL && tick
                && {1'b0, sleep_cnt_r} + 17'h1 >= {1'b0, sleep_per_r};
    wire rx_enter = state_r == ST_TUNE && settle_r == 16'h0;
    wire auto_out = duty == DUTY_WAKE_OUT || duty == DUTY_AUTO;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tick_cnt_r <= 7'h0;
        end else begin
            tick_cnt_r <= tick ? 7'h0 : tick_cnt_r + 7'h1;
        end
    end

    // Sleep wake-up counter
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || state_r != ST_SLEEP || wake) begin
            sleep_cnt_r <= 16'h0;
        end else if (tick) begin
            sleep_cnt_r <= sleep_cnt_r + 16'h1;
        end
    end

    // Commands first, then automatic moves
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_r  <= ST_SLEEP;
            settle_r <= 16'h0;
        end else if (cmd_wr && cmd != CMD_RX) begin
            case (cmd)
                CMD_SLEEP: state_r <= ST_SLEEP;
                CMD_STBY:  state_r <= ST_STBY;
                CMD_RFS:   state_r <= ST_RFS;
                default: ;
            endcase
        end else if (cmd_wr && state_r != ST_RX && state_r != ST_TUNE) begin
            state_r  <= ST_TUNE;
            settle_r <= state_r == ST_RFS ? SHORT_SETTLE : LONG_SETTLE;
        end else begin
            case (state_r)
                ST_TUNE: begin
                    if (rx_enter) begin
                        state_r <= ST_RX;
                    end else begin
                        settle_r <= settle_r - 16'h1;
                    end
                end
                ST_RX: begin
                    if (win_exit) begin
                        state_r <= auto_out ? ST_SLEEP : ST_STBY;
                    end
                end
                ST_SLEEP: begin
                    if (wake && (duty == DUTY_WAKE_RX || duty == DUTY_AUTO)) begin
                        state_r  <= ST_TUNE;
                        settle_r <= LONG_SETTLE;
                    end else if (wake) begin
                        state_r <= ST_STBY;
                    end
                end
                default: ;
            endcase
        end
    end

    assign rx_active_o = state_r == ST_TUNE || in_rx;

    ////////////////////////////////////////////////////////////////////////
    // Receive windows

    wire slv = ctrl_r[CTRL_SRC] ? phase_jump_detector_i : rssi_cmp_i;
    wire exp1 = tick && {1'b0, win_cnt_r} + 17'h1 >= {1'b0, t1_r};
    wire exp2 = tick && {1'b0, win_cnt_r} + 17'h1 >= {1'b0, t2_r};

    // Window conditions per policy
    always_comb begin
        case (ext)
            4'd1, 4'd4, 4'd5, 4'd11: hit1 = slv;
            4'd2, 4'd6, 4'd12:       hit1 = preamble_det_i;
            4'd3, 4'd7, 4'd13:       hit1 = slv && preamble_det_i;
            4'd8:  hit1 = preamble_det_i || sync_det_i;
            4'd9:  hit1 = preamble_det_i || node_det_i;
            4'd10: hit1 = preamble_det_i || sync_det_i || node_det_i;
            default: hit1 = 1'b0;
        endcase
    end

    always_comb begin
        win_nxt  = win_r;
        win_exit = 1'b0;
        case (win_r)
            WIN_T1: begin
                if (hit1 && ext <= 4'd3) begin
                    win_nxt = WIN_HOST;
                end else if (hit1 && ext == 4'd4) begin
                    win_nxt = WIN_HOLD;
                end else if (hit1) begin
                    win_nxt = WIN_T2;
                end else if (exp1) begin
                    win_exit = 1'b1;
                end
            end
            WIN_T2: begin
                if (ext >= 4'd11 && sync_det_i) begin
                    win_nxt = WIN_HOST;
                end else if (exp2) begin
                    win_exit = 1'b1;
                end
            end
            WIN_HOLD: win_exit = !slv;
            default: ;
        endcase
    end

    // Window state, started on receive entry only with the timer on
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || (!in_rx && !rx_enter) || win_exit) begin
            win_r <= WIN_IDLE;
        end else if (rx_enter) begin
            win_r <= tmr_en ? WIN_T1 : WIN_IDLE;
        end else begin
            win_r <= win_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || win_nxt != win_r || !in_rx) begin
            win_cnt_r <= 16'h0;
        end else if (tick) begin
            win_cnt_r <= win_cnt_r + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Packet handler

    wire [7:0] new_byte  = {sh_r, demod_bit_i};
    wire       byte_done = ph_on_r && demod_bit_vld_i && bit_cnt_r == 3'h7;

    // Frame length from layout
    always_comb begin
        tot_nxt = total_r;
        if (lay_r == LAY_LEN_FIRST && byte_idx_r == 9'h0) begin
            tot_nxt = {1'b0, new_byte} + 9'h1;
        end else if (lay_r == LAY_LEN_AFTER && byte_idx_r == 9'h1) begin
            tot_nxt = {1'b0, new_byte} + 9'h2;
        end
    end

    wire frame_end = byte_done && byte_idx_r + 9'h1 >= tot_nxt;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !in_rx || !pkt_mode || frame_end) begin
            ph_on_r    <= 1'b0;
            bit_cnt_r  <= 3'h0;
            sh_r       <= 7'h0;
            byte_idx_r <= 9'h0;
            total_r    <= 9'h1FF;
        end else if (!ph_on_r) begin
            ph_on_r <= sync_det_i;
            total_r <= lay_r == LAY_FIXED ? {1'b0, flen_r} : 9'h1FF;
        end else if (demod_bit_vld_i) begin
            sh_r      <= new_byte[6:0];
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_done) begin
                byte_idx_r <= byte_idx_r + 9'h1;
                total_r    <= tot_nxt;
            end
        end
    end

    // Decoded bytes go to the FIFO only in packet mode
    assign fq.wr_en   = byte_done && pkt_mode && !fq.full;
    assign fq.wr_data = new_byte;

    rx_byte_fifo #(.AW(FIFO_AW)) u_fifo (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .f         (fq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags, set wins over a software clear

    wire [5:0] flag_set = {byte_done && pkt_mode && fq.full, win_exit, frame_end,
                           in_rx && node_det_i, in_rx && sync_det_i,
                           in_rx && preamble_det_i};
    wire [5:0] flag_clr = bus_wr && addr == ADDR_FLAGS ? pwdata_i[5:0] : 6'h0;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            flags_r <= 6'h0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins and front-end settings

    // Direct bit stream on the selected pin
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            gpio_o    <= 3'h0;
            gpio_oe_o <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                gpio_oe_o[i] <= !pkt_mode && dout_sel == 2'(i);
                gpio_o[i]    <= !pkt_mode && dout_sel == 2'(i) && in_rx && demod_bit_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            {limiter_level_trim_o, mixer_current_set_o,
             frontend_amp_config_o, frontend_amp_current_o} <= PWR_LOW_CFG;
        end else begin
            {limiter_level_trim_o, mixer_current_set_o,
             frontend_amp_config_o, frontend_amp_current_o} <= power_cfg(pwr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_DIRECT_NO_FIFO: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !pkt_mode |=> fq.level <= $past(fq.level)) else $error("FIFO written in direct mode");
    AST_DOUT_PIN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!pkt_mode && in_rx && dout_sel == 2'h1) ##1 $stable(ctrl_r)
        |-> gpio_oe_o == 3'h2 && gpio_o[1] == $past(demod_bit_i))
        else $error("Direct bit not on selected pin");
    AST_TIMER_GATE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        rx_enter && !tmr_en |=> win_r == WIN_IDLE) else $error("Window without timer");
    AST_POLICY0: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (win_r == WIN_T1 && ext == 4'd0 && exp1 && !cmd_wr) |=> state_r != ST_RX)
        else $error("Policy 0 did not leave receive");
    AST_HOLD_EXIT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (win_r == WIN_HOLD && !slv && !cmd_wr) |=> state_r != ST_RX && win_r == WIN_IDLE)
        else $error("Hold did not end on level loss");
    AST_T2_START: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (win_r == WIN_T1 && ext >= 4'd8 && ext <= 4'd10 && hit1 && in_rx && !cmd_wr)
        |=> win_r == WIN_T2 && win_cnt_r == 16'h0) else $error("Second window not started");
    AST_RFS_TO_RX: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state_r == ST_RFS && cmd_wr && cmd == CMD_RX)
        |=> state_r == ST_TUNE && settle_r == SHORT_SETTLE) else $error("Bad tune time");
    AST_PRE_STICKY: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (in_rx && preamble_det_i) |=> flags_r[FLG_PRE]
        ##1 (flags_r[FLG_PRE] || $past(flag_clr[FLG_PRE]))) else $error("Preamble flag lost");
    AST_PWR_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        pwr == 2'h2 |=> frontend_amp_config_o == 2'h3 && limiter_level_trim_o == 2'h1)
        else $error("High power fields wrong");
endmodule

`default_nettype wire

// ===== shared/rx_ctl_pkg.sv
// Contract
// - Direct mode detects preamble/sync only, FIFO idle, bits go out on a pin; code also sets the node flag in direct mode.
// - Packet mode stores decoded bytes in the FIFO, readable from the bus.
// - Direct bit output selectable onto any of the three general pins.
// - Handler supports length-before-node, length-after-node and fixed frames.
// - Packet mode decodes demodulator bits in the handler before FIFO writes.
// - Five duty-cycle options from fully manual to fully automatic.
// - Window extension policies act only while the receive timer is enabled.
// - Policy 0 never extends; receive ends when the first window expires.
// - Policies 1-3 stop the first window on their condition; host takes over.
// - Policy 4 holds receive while signal level valid, exits when it drops.
// - Policies 8-10 start the second window on their condition; exit at expiry.
// - Policies 11-13 start second window; sync hands over, else exit at expiry.
// - Signal level valid comes from RSSI compare or phase jump detector.
// - First and second window lengths are programmable registers.
// - Front-end power level sets four 2-bit bias fields per the level table.
// - Moving from synth-ready into receive takes 20 us.
// - Preamble-found flag sets on preamble and stays until the host clears it.
`default_nettype none

package rx_ctl_pkg;

    // Timing
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned RFS_TO_RX_US  = 20;
    localparam int unsigned RFS_TO_RX_CYC = RFS_TO_RX_US * CLK_MHZ;
    localparam int unsigned PLL_SETTLE_US = 350;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYC      = TICK_US * CLK_MHZ;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_WIN    = 8'h04;
    localparam logic [7:0] ADDR_SLEEP  = 8'h08;
    localparam logic [7:0] ADDR_CMD    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FLAGS  = 8'h14;
    localparam logic [7:0] ADDR_FIFO   = 8'h18;
    localparam logic [7:0] ADDR_PKT    = 8'h1C;

    // Control field positions
    localparam int unsigned CTRL_PKT  = 0;
    localparam int unsigned CTRL_DOUT = 1;
    localparam int unsigned CTRL_TEN  = 3;
    localparam int unsigned CTRL_EXT  = 4;
    localparam int unsigned CTRL_SRC  = 8;
    localparam int unsigned CTRL_DUTY = 9;
    localparam int unsigned CTRL_PWR  = 12;

    // Flag bit positions
    localparam int unsigned FLG_PRE = 0;
    localparam int unsigned FLG_SYN = 1;
    localparam int unsigned FLG_NOD = 2;
    localparam int unsigned FLG_PKT = 3;
    localparam int unsigned FLG_TMO = 4;
    localparam int unsigned FLG_OVF = 5;

    // Reset values
    localparam logic [13:0] CTRL_RST  = 14'h0006;
    localparam logic [15:0] T1_RST    = 16'h0064;
    localparam logic [15:0] T2_RST    = 16'h00C8;
    localparam logic [15:0] SLEEP_RST = 16'h03E8;
    localparam logic [7:0]  FLEN_RST  = 8'h10;

    // Commands
    localparam logic [3:0] CMD_SLEEP = 4'h1;
    localparam logic [3:0] CMD_STBY  = 4'h2;
    localparam logic [3:0] CMD_RFS   = 4'h3;
    localparam logic [3:0] CMD_RX    = 4'h5;

    // Frame layouts
    localparam logic [1:0] LAY_LEN_FIRST = 2'h0;
    localparam logic [1:0] LAY_LEN_AFTER = 2'h1;
    localparam logic [1:0] LAY_FIXED     = 2'h2;

    // Duty-cycle options
    localparam logic [2:0] DUTY_MANUAL   = 3'h0;
    localparam logic [2:0] DUTY_WAKE     = 3'h1;
    localparam logic [2:0] DUTY_WAKE_RX  = 3'h2;
    localparam logic [2:0] DUTY_WAKE_OUT = 3'h3;
    localparam logic [2:0] DUTY_AUTO     = 3'h4;

    // Front-end settings {limiter, mixer, amp mode, amp current}
    localparam logic [7:0] PWR_LOW_CFG  = 8'hA5;
    localparam logic [7:0] PWR_MED_CFG  = 8'hA6;
    localparam logic [7:0] PWR_HIGH_CFG = 8'h6E;

    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_STBY  = 3'b001,
        ST_RFS   = 3'b011,
        ST_TUNE  = 3'b010,
        ST_RX    = 3'b110
    } radio_state_e;

    typedef enum logic [2:0] {
        WIN_IDLE = 3'b000,
        WIN_T1   = 3'b001,
        WIN_T2   = 3'b011,
        WIN_HOLD = 3'b010,
        WIN_HOST = 3'b110
    } win_state_e;

    // Power level to bias fields
    function automatic logic [7:0] power_cfg(input logic [1:0] lvl);
        case (lvl)
            2'h0: power_cfg = PWR_LOW_CFG;
            2'h1: power_cfg = PWR_MED_CFG;
            default: power_cfg = PWR_HIGH_CFG;
        endcase
    endfunction

endpackage

`default_nettype wire

// ===== shared/fifo_if.sv
`default_nettype none

interface fifo_if #(parameter int unsigned AW = 6);
    logic          wr_en;
    logic [7:0]    wr_data;
    logic          rd_en;
    logic [7:0]    rd_data;
    logic          full;
    logic          empty;
    logic [AW:0]   level;

    modport ctl (output wr_en, wr_data, rd_en, input rd_data, full, empty, level);
    modport mem (input wr_en, wr_data, rd_en, output rd_data, full, empty, level);
endinterface

`default_nettype wire

// ===== src/rx_byte_fifo.sv
`default_nettype none

module rx_byte_fifo #(
    parameter int unsigned AW = 6
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    fifo_if.mem       f
);
    logic [7:0]  mem_r [2**AW];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic [7:0]  rd_data_r;

    // Status from pointers
    assign f.full    = (wp_r ^ rp_r) == {1'b1, {AW{1'b0}}};
    assign f.empty   = wp_r == rp_r;
    assign f.level   = wp_r - rp_r;
    assign f.rd_data = rd_data_r;

    // Write side
    always_ff @(posedge sys_clk_i) begin
        if (f.wr_en && !f.full) begin
            mem_r[wp_r[AW-1:0]] <= f.wr_data;
        end
    end

    // Pointers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (f.wr_en && !f.full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (f.rd_en && !f.empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    // Registered read data
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_data_r <= 8'h00;
        end else if (f.rd_en && !f.empty) begin
            rd_data_r <= mem_r[rp_r[AW-1:0]];
        end
    end
endmodule

`default_nettype wire

// ===== bench/demod_src.sv
`default_nettype none
// Demodulator and detector stand-in
module demod_src (
    input  wire logic clk_i,
    output logic      bit_o,
    output logic      vld_o,
    output logic      pre_o,
    output logic      syn_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {bit_o, vld_o, pre_o, syn_o} = 4'h0;
    end
    // One strobed bit; line flips once released
    task automatic put_bit(input logic b);
        @(posedge clk_i);
        bit_o <= b;
        vld_o <= 1'b1;
        @(posedge clk_i);
        vld_o <= 1'b0;
        @(posedge clk_i);
        bit_o <= ~b;
    endtask
    // One-cycle sync or preamble pulse
    task automatic pulse(input logic s);
        @(posedge clk_i);
        syn_o <= s;
        pre_o <= ~s;
        @(posedge clk_i);
        {pre_o, syn_o} <= 2'h0;
    endtask
endmodule
`default_nettype wire

// ===== bench/rx_path_ctl_tb.sv
`default_nettype none
module rx_path_ctl_tb import rx_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic        pready, pslverr, perr, sbit, svld, spre, ssyn, rx_act;
    logic [2:0]  gpio, gpio_oe;
    logic [1:0]  lim, mix, amode, acur;
    logic        rssi = 1'b0, phase_jump_detector = 1'b0, node = 1'b0;
    logic [7:0]  pwr_tab [3] = '{8'hA5, 8'hA6, 8'h6E};
    int          err_count = 0, compares = 0, cyc = 0;
    always #5 clk = ~clk;
    rx_path_ctl #(.PLL_SETTLE_CYC(50)) i_dut (.sys_clk_i(clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .demod_bit_i(sbit), .demod_bit_vld_i(svld), .rssi_cmp_i(rssi),
        .phase_jump_detector_i(phase_jump_detector), .preamble_det_i(spre), .sync_det_i(ssyn),
        .node_det_i(node), .gpio_o(gpio), .gpio_oe_o(gpio_oe), .rx_active_o(rx_act),
        .limiter_level_trim_o(lim), .mixer_current_set_o(mix),
        .frontend_amp_config_o(amode), .frontend_amp_current_o(acur));
    demod_src i_src (.clk_i(clk), .bit_o(sbit), .vld_o(svld), .pre_o(spre), .syn_o(ssyn));
    ////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Bus transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Enter receive through synth-ready
    task automatic rx_go(input logic [31:0] c);
        apb(1'b1, ADDR_CTRL, c);
        apb(1'b1, ADDR_CMD, 32'(CMD_RFS));
        apb(1'b1, ADDR_CMD, 32'(CMD_RX));
        repeat (RFS_TO_RX_CYC + 2) @(posedge clk);
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, ADDR_WIN, 32'h0);
        chk(rd, 32'h00C8_0064);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(perr), 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CTRL, 32'h6 | (i << 12));
            repeat (2) @(posedge clk);
            chk({lim, mix, amode, acur}, pwr_tab[i]);
        end
        rx_go(32'h2);
        chk({rx_act, gpio_oe}, 32'hA);
        for (int b = 0; b < 2; b++) begin
            i_src.put_bit(b[0]);
            chk(gpio, {b[0], 1'b0});
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, ADDR_CMD, 32'(CMD_STBY));
        apb(1'b1, ADDR_PKT, 32'h6);
        rx_go(32'h7);
        i_src.pulse(1'b1);
        for (int k = 7; k >= 0; k--) i_src.put_bit(pwr_tab[2][k]);
        i_src.pulse(1'b0);
        apb(1'b0, ADDR_FIFO, 32'h0);
        chk(rd, 32'h6E);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0B);
        apb(1'b1, ADDR_FLAGS, 32'h0A);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h01);
        apb(1'b1, ADDR_FLAGS, 32'h01);
        apb(1'b1, ADDR_CMD, 32'(CMD_STBY));
        apb(1'b1, ADDR_WIN, 32'h0005_0001);
        rx_go(32'h8);
        repeat (250) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h01);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, ADDR_FLAGS, 32'h10);
        apb(1'b1, ADDR_WIN, 32'h0005_0003);
        rx_go(32'h88);
        @(posedge clk);
        node <= 1'b1;
        @(posedge clk);
        node <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0E);
        i_src.pulse(1'b0);
        repeat (300) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h1E);
        repeat (500) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h01);
        rssi <= 1'b1;
        rx_go(32'h48);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h16);
        @(posedge clk);
        {rssi, phase_jump_detector} <= 2'b01;
        repeat (3) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
